// *** rtl/bde_consts.svh ***
// Constants for the decimal adjust, decrement and compare-skip execution block.
`ifndef BDE_CONSTS_SVH
`define BDE_CONSTS_SVH
`define BDE_OP_DECADJ      16'h0007
`define BDE_DEC_PFX        6'h01
`define BDE_DEC_PFX_LSB    10
`define BDE_CPL_PFX        7'h30
`define BDE_CPL_PFX_LSB    9
`define BDE_DEST_BIT       9
`define BDE_ACC_BIT        8
`define BDE_IDX_LIMIT      8'h5f
`define BDE_NIB_MAX        4'h9
`define BDE_NIB_ADJ        4'h6
`define BDE_W_RST          8'h00
`define BDE_STAT_RST       5'h00
`define BDE_BSR_RST        4'h0
`define BDE_OFF_REG_CTRL   12'h000
`define BDE_OFF_REG_W      12'h004
`define BDE_OFF_REG_STATUS 12'h008
`define BDE_OFF_REG_BSR    12'h00c
`define BDE_OFF_REG_IDX_BASE 12'h010
`define BDE_OFF_REG_INSTR  12'h014
`define BDE_OFF_REG_NEXT   12'h018
`define BDE_OFF_REG_FILE   12'h01c
`define BDE_OFF_REG_EXEC   12'h020
`endif

// *** rtl/bde_pkg.sv ***
// Types shared by the execution block.
package bde_pkg;
    typedef enum logic [1:0] {
        BDE_IDLE,
        BDE_MEM_RD,
        BDE_SKIP
    } bde_state_t;
endpackage : bde_pkg

// *** rtl/bde_exec.sv ***
// Execution of decimal adjust, decrement file and compare-less-skip, APB controlled.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "bde_consts.svh"
module bde_exec (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_re,
    output logic             mem_we,
    output logic      [11:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata
);
    // ------------------------------------------------------------
    // Software visible state
    // ------------------------------------------------------------
    logic [7:0]  w_acc, next_w_acc;
    logic [4:0]  stat, next_stat;          // Negative, overflow, zero, digit carry, carry.
    logic [3:0]  bank_select_register, next_bank_select_register;
    logic [11:0] index_base, next_index_base;
    logic        ext_en, next_ext_en;
    logic [15:0] instr, next_instr;
    logic        skip_two_word, next_skip_two_word;
    logic        skip_flag, next_skip_flag;
    logic [7:0]  file_val, next_file_val;
    logic [1:0]  nop_left, next_nop_left;
    logic [1:0]  nop_cnt, next_nop_cnt;
    bde_pkg::bde_state_t state, next_state;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr;
    logic        next_mem_re, next_mem_we;
    logic [11:0] next_mem_addr;
    logic [7:0]  next_mem_wdata;

    // Decode helpers.
    logic        is_decadj, is_dec, is_cpl, acc_a, dst_d;
    logic [7:0]  faddr;
    logic [11:0] eff_addr;
    logic [3:0]  lo_adj, hi_adj;
    logic        lo_fix, hi_fix;
    logic [4:0]  lo_sum, hi_base;
    logic [8:0]  dec_sum;
    logic [4:0]  dec_lo;
    logic [7:0]  dec_res;
    logic        wr_acc, setup_acc, go;

    // ------------------------------------------------------------
    // Instruction decode and addressing
    // ------------------------------------------------------------
    // Combinational decode of the held instruction word.
    always_comb begin
        is_decadj = (instr == `BDE_OP_DECADJ);
        is_dec    = (instr[15:`BDE_DEC_PFX_LSB] == `BDE_DEC_PFX);
        is_cpl    = (instr[15:`BDE_CPL_PFX_LSB] == `BDE_CPL_PFX);
        dst_d     = instr[`BDE_DEST_BIT];
        acc_a     = instr[`BDE_ACC_BIT];
        faddr     = instr[7:0];
        if (!acc_a && ext_en && faddr <= `BDE_IDX_LIMIT) begin
            eff_addr = index_base + {4'h0, faddr};
        end else if (!acc_a) begin
            eff_addr = faddr[7] ? {4'hf, faddr} : {4'h0, faddr};
        end else begin
            eff_addr = {bank_select_register, faddr};
        end
    end

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    // Decimal adjust and decrement datapaths.
    always_comb begin
        lo_fix  = (w_acc[3:0] > `BDE_NIB_MAX) || stat[1];
        lo_adj  = lo_fix ? `BDE_NIB_ADJ : 4'h0;
        lo_sum  = {1'b0, w_acc[3:0]} + {1'b0, lo_adj};
        // The low nibble's carry must reach the high nibble before it is tested,
        // otherwise sums such as 15 + 15 come out one ten short.
        hi_base = {1'b0, w_acc[7:4]} + {4'h0, lo_sum[4]};
        hi_fix  = (hi_base > {1'b0, `BDE_NIB_MAX}) || stat[0];
        hi_adj  = hi_fix ? `BDE_NIB_ADJ : 4'h0;
        // Decrement as f + 0xFF so carry and digit carry are the no-borrow outputs.
        dec_sum = {1'b0, file_val} + 9'h0ff;
        dec_lo  = {1'b0, file_val[3:0]} + 5'h0f;
        dec_res = dec_sum[7:0];
    end

    // ------------------------------------------------------------
    // Sequencer and APB slave
    // ------------------------------------------------------------
    // Next-state logic for execution and the register port.
    always_comb begin
        next_w_acc          = w_acc;
        next_stat           = stat;
        next_bank_select_register = bank_select_register;
        next_index_base     = index_base;
        next_ext_en         = ext_en;
        next_instr          = instr;
        next_skip_two_word  = skip_two_word;
        next_skip_flag      = skip_flag;
        next_file_val       = file_val;
        next_nop_left       = nop_left;
        next_nop_cnt        = nop_cnt;
        next_state          = state;
        next_prdata         = prdata;
        next_pready         = 1'b0;
        next_pslverr        = 1'b0;
        next_mem_re         = 1'b0;
        next_mem_we         = 1'b0;
        next_mem_addr       = mem_addr;
        next_mem_wdata      = mem_wdata;
        setup_acc           = psel && !penable;
        wr_acc              = psel && penable && pready && pwrite;
        go                  = 1'b0;
        // The setup cycle decides ready, error and read data, so they stand in the access phase.
        if (setup_acc && pwrite) begin
            next_pready = 1'b1;
            case (paddr)
                `BDE_OFF_REG_CTRL, `BDE_OFF_REG_W, `BDE_OFF_REG_STATUS, `BDE_OFF_REG_BSR,
                `BDE_OFF_REG_IDX_BASE, `BDE_OFF_REG_INSTR, `BDE_OFF_REG_NEXT,
                `BDE_OFF_REG_EXEC:   next_pslverr = 1'b0;
                default:             next_pslverr = 1'b1;
            endcase
        end else if (setup_acc) begin
            next_pready = 1'b1;
            case (paddr)
                `BDE_OFF_REG_CTRL:   next_prdata = {31'h0, ext_en};
                `BDE_OFF_REG_W:      next_prdata = {24'h0, w_acc};
                `BDE_OFF_REG_STATUS: next_prdata = {27'h0, stat};
                `BDE_OFF_REG_BSR:    next_prdata = {28'h0, bank_select_register};
                `BDE_OFF_REG_IDX_BASE: next_prdata = {20'h0, index_base};
                `BDE_OFF_REG_INSTR:  next_prdata = {16'h0, instr};
                `BDE_OFF_REG_NEXT:   next_prdata = {31'h0, skip_two_word};
                `BDE_OFF_REG_FILE:   next_prdata = {24'h0, file_val};
                `BDE_OFF_REG_EXEC:   next_prdata = {26'h0, nop_cnt, skip_flag,
                                                    state != bde_pkg::BDE_IDLE, 2'h0};
                default: begin
                    next_prdata  = 32'h0000_0000;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        // A write lands only at the edge that completes the access phase.
        if (wr_acc) begin
            case (paddr)
                `BDE_OFF_REG_CTRL:     next_ext_en = pwdata[0];
                `BDE_OFF_REG_W:        next_w_acc = pwdata[7:0];
                `BDE_OFF_REG_STATUS:   next_stat = pwdata[4:0];
                `BDE_OFF_REG_BSR:      next_bank_select_register = pwdata[3:0];
                `BDE_OFF_REG_IDX_BASE: next_index_base = pwdata[11:0];
                `BDE_OFF_REG_INSTR:    next_instr = pwdata[15:0];
                `BDE_OFF_REG_NEXT:     next_skip_two_word = pwdata[0];
                `BDE_OFF_REG_EXEC:     go = (state == bde_pkg::BDE_IDLE);
                default:               go = 1'b0;
            endcase
        end
        case (state)
            bde_pkg::BDE_IDLE: begin
                if (go && is_decadj) begin
                    // One cycle: read the accumulator, adjust both digits, write it back.
                    next_w_acc = {hi_base[3:0] + hi_adj, lo_sum[3:0]};
                    if (hi_fix) begin
                        next_stat[0] = 1'b1;
                    end
                end else if (go && (is_dec || is_cpl)) begin
                    // Counters of the previous command start afresh, so no stale count shows.
                    next_mem_re    = 1'b1;
                    next_mem_addr  = eff_addr;
                    next_nop_cnt   = 2'h0;
                    next_skip_flag = 1'b0;
                    next_state     = bde_pkg::BDE_MEM_RD;
                end
            end
            bde_pkg::BDE_MEM_RD: begin
                // The operand is taken at the edge that closes the read strobe's cycle.
                next_file_val = mem_rdata;
                next_state    = bde_pkg::BDE_IDLE;
                if (is_dec) begin
                    next_state    = bde_pkg::BDE_SKIP;
                    next_nop_left = 2'h0;
                end else if (mem_rdata < w_acc) begin
                    next_skip_flag = 1'b1;
                    next_nop_left  = skip_two_word ? 2'h2 : 2'h1;
                    next_state     = bde_pkg::BDE_SKIP;
                end else begin
                    next_skip_flag = 1'b0;
                end
            end
            bde_pkg::BDE_SKIP: begin
                if (is_dec && nop_left == 2'h0) begin
                    // Decrement result and flags from the fetched operand.
                    next_stat = {dec_res[7], file_val == 8'h80, dec_res == 8'h00,
                                 dec_lo[4], dec_sum[8]};
                    if (dst_d) begin
                        next_mem_we    = 1'b1;
                        next_mem_wdata = dec_res;
                    end else begin
                        next_w_acc = dec_res;
                    end
                    next_state = bde_pkg::BDE_IDLE;
                end else begin
                    // Discarded fetch executes as a no-operation cycle.
                    next_nop_cnt  = nop_cnt + 2'h1;
                    next_nop_left = nop_left - 2'h1;
                    if (nop_left == 2'h1) begin
                        next_state = bde_pkg::BDE_IDLE;
                    end
                end
            end
            default: next_state = bde_pkg::BDE_IDLE;
        endcase
    end

    // Registers only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_acc                <= `BDE_W_RST;
            stat                 <= `BDE_STAT_RST;
            bank_select_register <= `BDE_BSR_RST;
            index_base           <= 12'h000;
            ext_en               <= 1'b0;
            instr                <= 16'h0000;
            skip_two_word        <= 1'b0;
            skip_flag            <= 1'b0;
            file_val             <= 8'h00;
            nop_left             <= 2'h0;
            nop_cnt              <= 2'h0;
            state                <= bde_pkg::BDE_IDLE;
            prdata               <= 32'h0000_0000;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
            mem_re               <= 1'b0;
            mem_we               <= 1'b0;
            mem_addr             <= 12'h000;
            mem_wdata            <= 8'h00;
        end else begin
            w_acc                <= next_w_acc;
            stat                 <= next_stat;
            bank_select_register <= next_bank_select_register;
            index_base           <= next_index_base;
            ext_en               <= next_ext_en;
            instr                <= next_instr;
            skip_two_word        <= next_skip_two_word;
            skip_flag            <= next_skip_flag;
            file_val             <= next_file_val;
            nop_left             <= next_nop_left;
            nop_cnt              <= next_nop_cnt;
            state                <= next_state;
            prdata               <= next_prdata;
            pready               <= next_pready;
            pslverr              <= next_pslverr;
            mem_re               <= next_mem_re;
            mem_we               <= next_mem_we;
            mem_addr             <= next_mem_addr;
            mem_wdata            <= next_mem_wdata;
        end
    end
endmodule : bde_exec

// *** dv/bde_exec_monitor.sv ***
// Checker of bus and data memory timing for the execution block.
`timescale 1ns/100ps
module bde_exec_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mem_re,
    input wire logic        mem_we,
    input wire logic [11:0] mem_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A decrement reads its operand and writes the result two cycles later.
    sequence rd_then_wr;
        mem_re ##2 mem_we;
    endsequence
    a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_unmapped: assert property (psel && !penable && paddr > 12'h020 |=> pslverr)
        else $error("no error on unmapped");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_re_pulse: assert property (mem_re |=> !mem_re) else $error("read too long");
    a_we_pulse: assert property (mem_we |=> !mem_we) else $error("write too long");
    a_we_after_rd: assert property (mem_we |-> $past(mem_re, 2))
        else $error("write unread");
    a_we_same_addr: assert property (mem_we |-> mem_addr == $past(mem_addr, 2))
        else $error("write address moved");
    c_rd_wr: cover property (rd_then_wr);
endmodule : bde_exec_monitor
bind bde_exec bde_exec_monitor u_mon (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .mem_re(mem_re), .mem_we(mem_we),
    .mem_addr(mem_addr));

// *** dv/tb.sv ***
// Self-checking bench for the execution block.
`timescale 1ns/100ps
`include "bde_consts.svh"
module tb;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_re, mem_we, err;
    logic [11:0] paddr, mem_addr, ra, wa;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  mem_wdata, mem_rdata, fval, wd;
    int          bad_count, checks_done, cyc, wcnt;
    bde_exec DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Data memory stand-in and the run limit. The operand stands while the read strobe
    // is high and turns to its inverse once the strobe has been seen, so a late sample fails.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        mem_rdata <= mem_re ? ~fval : fval;
        if (mem_re) ra <= mem_addr;
        if (mem_we) begin
            wa <= mem_addr;
            wd <= mem_wdata;
            wcnt <= wcnt + 1;
        end
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // One APB transfer: setup, access held until pready is sampled high at a rising
    // edge, data taken at that edge, then one idle edge before the next request.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic run(input logic [15:0] ins);
        apb(1'b1, `BDE_OFF_REG_INSTR, {16'h0000, ins});
        apb(1'b1, `BDE_OFF_REG_EXEC, 32'h1);
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, `BDE_OFF_REG_EXEC, 32'h0);
            if (rd[2] === 1'b0) break;
        end
    endtask : run
    function automatic logic [7:0] bcd(input int v);
        return {4'(v / 10), 4'(v % 10)};
    endfunction : bcd
    // Main sequence: decimal adjust, decrement, compare-skip, unmapped access.
    initial begin
        logic [8:0] s;
        logic [7:0] f, r, fa;
        logic [3:0] bk;
        logic [11:0] base, ea;
        logic d, a, ex, two, dc;
        int x, y;
        {rst_n, psel, penable, pwrite, paddr, pwdata, cyc, wcnt, fval} = '0;
        void'($urandom(15));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            x = i == 0 ? 99 : i == 1 ? 15 : $urandom % 100;
            y = i == 0 ? 99 : i == 1 ? 15 : $urandom % 100;
            s = bcd(x) + bcd(y);
            dc = ({1'b0, bcd(x) & 8'h0f} + {1'b0, bcd(y) & 8'h0f}) > 9'h00f;
            apb(1'b1, `BDE_OFF_REG_W, {24'h0, s[7:0]});
            apb(1'b1, `BDE_OFF_REG_STATUS, {30'h0, dc, s[8]});
            run(16'h0007);
            apb(1'b0, `BDE_OFF_REG_W, 32'h0);
            chk(rd[7:0], bcd((x + y) % 100), "adjusted sum");
            apb(1'b0, `BDE_OFF_REG_STATUS, 32'h0);
            chk(rd[0], (x + y) > 99, "adjust carry");
        end
        $display("decimal adjust test done");
        for (int i = 0; i < 16; i++) begin
            f = i < 4 ? 8'(32'h10018000 >> (8 * i)) : 8'($urandom);
            fa = i < 4 ? 8'h5f + 8'(i) : 8'($urandom);
            {d, a, ex, bk, base} = 19'($urandom);
            fval = f;
            r = f - 8'h01;
            ea = a ? {bk, fa} : (ex && fa <= 8'h5f) ? base + 12'(fa) :
                 fa < 8'h80 ? 12'(fa) : {4'hf, fa};
            x = wcnt;
            apb(1'b1, `BDE_OFF_REG_CTRL, {31'h0, ex});
            apb(1'b1, `BDE_OFF_REG_BSR, {28'h0, bk});
            apb(1'b1, `BDE_OFF_REG_IDX_BASE, {20'h0, base});
            apb(1'b1, `BDE_OFF_REG_W, 32'h000000a5);
            run({6'h01, d, a, fa});
            chk(ra, ea, "operand address");
            chk(wcnt - x, d, "write back count");
            if (d) chk({wa, wd}, {ea, r}, "write back");
            apb(1'b0, `BDE_OFF_REG_W, 32'h0);
            chk(rd[7:0], d ? 8'ha5 : r, "accumulator");
            apb(1'b0, `BDE_OFF_REG_STATUS, 32'h0);
            chk(rd[4:0], {r[7], f == 8'h80, r == 8'h00, f[3:0] != 4'h0, f != 8'h00},
                "flags");
        end
        $display("decrement test done");
        for (int i = 0; i < 10; i++) begin
            {f, r, two} = 17'($urandom);
            if (i < 2) r = f;
            fval = f;
            apb(1'b1, `BDE_OFF_REG_W, {24'h0, r});
            apb(1'b1, `BDE_OFF_REG_NEXT, {31'h0, two});
            run({7'h30, 1'b1, 8'($urandom)});
            chk(rd[5:3], f < r ? {two ? 2'h2 : 2'h1, 1'b1} : 3'h0, "skip cost");
        end
        $display("compare skip test done");
        apb(1'b0, 12'h024, 32'h0);
        chk(err, 1'b1, "unmapped error");
        $display("unmapped access test done");
        summarize();
    end
endmodule : tb
